/* File: scanner_frame_receiver.v */
// Implementation choices: the register offsets and register access over APB.
`timescale 1ns/1ns
`default_nettype none
`include "scanner_frame_receiver_defs.vh"

// Summary of operation
// - Rate codes 0 to 4 give 1200, 2400, 4800, 9600 or 19200 bps.
// - Characters are always 8 data bits, no parity, one stop bit.
// - After reset the rate code is 3, which is 9600 bps.
// - Characters between frame-open and frame-close form the code.
// - A repeated frame-open discards the partial code and restarts.
// - The frame-open character is 8 bits and resets to 0x02.
// - The frame-close character is 8 bits and resets to 0x0D.
// - Extraction length accepts 1 to 40 and resets to 40.
// - The record is the substring from start, cut at the code end.
// - Every valid framed code yields one attendance record.
// - Start counts from 1, accepts 1 to 40, resets to 1; short codes fail.
// - A prefix of 0 to 16 characters must match the code's head.
module scanner_frame_receiver #(
  parameter CLK_HZ = `CLK_HZ,
  parameter CODE_CHARS = 40
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg pslverr,
  output reg [31:0] prdata,
  // scanner serial input
  input wire scan_rxd,
  // attendance record
  output reg rec_valid_q,
  output reg rec_reject_q,
  output reg [5:0] rec_len_q,
  output reg [8*CODE_CHARS-1:0] rec_code_q
);

  // configuration
  reg [2:0] rate_q;
  reg [7:0] open_char_q;
  reg [7:0] close_char_q;
  reg [5:0] ext_start_q;
  reg [5:0] extract_length_q;
  reg [4:0] pfx_len_q;
  reg [127:0] leading_code_filter_q;

  // collection state
  reg [7:0] code_mem [0:CODE_CHARS-1];
  reg collecting_q;
  reg overflow_q;
  reg [5:0] cnt_q;
  reg done_q;
  reg [15:0] acc_cnt_q;
  reg [15:0] rej_cnt_q;

  wire [7:0] rx_data;
  wire rx_valid;

  serial_byte_rx #(
    .CLK_HZ(CLK_HZ)
  ) u_rx (
    .pclk(pclk),
    .presetn(presetn),
    .rate(rate_q),
    .rxd(scan_rxd),
    .rx_data_q(rx_data),
    .rx_valid_q(rx_valid),
    .rx_ferr_q()
  );

  // true when a setting value lies in 1..40
  function in_range;
    input [5:0] v;
    begin
      in_range = (v != 6'h00) && (v <= `CODE_MAX);
    end
  endfunction

  // apb access: zero wait states, every access completes in two cycles
  wire setup = psel && !penable;
  wire wr = psel && penable && pwrite;
  reg mapped;

  assign pready = 1'b1;

  always @* begin
    case (paddr)
      `OFS_RATE, `OFS_FRAME, `OFS_EXTRACT, `OFS_PFX_LEN,
      `OFS_PFX_W0, `OFS_PFX_W1, `OFS_PFX_W2, `OFS_PFX_W3,
      `OFS_STATUS, `OFS_COUNTS, `OFS_LAST: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // read data is captured in the setup cycle so prdata comes from flops
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      pslverr <= !mapped;
      prdata <= 32'h0000_0000;
      if (!pwrite) begin
        case (paddr)
          `OFS_RATE: prdata <= {29'h0000_0000, rate_q};
          `OFS_FRAME: prdata <= {16'h0000, close_char_q, open_char_q};
          `OFS_EXTRACT: prdata <= {18'h0_0000, extract_length_q,
                                   2'b00, ext_start_q};
          `OFS_PFX_LEN: prdata <= {27'h000_0000, pfx_len_q};
          `OFS_PFX_W0: prdata <= leading_code_filter_q[31:0];
          `OFS_PFX_W1: prdata <= leading_code_filter_q[63:32];
          `OFS_PFX_W2: prdata <= leading_code_filter_q[95:64];
          `OFS_PFX_W3: prdata <= leading_code_filter_q[127:96];
          `OFS_STATUS: prdata <= {15'h0000, overflow_q, 2'b00, cnt_q,
                                  7'h00, collecting_q};
          `OFS_COUNTS: prdata <= {rej_cnt_q, acc_cnt_q};
          `OFS_LAST: prdata <= {26'h000_0000, rec_len_q};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // configuration writes; out-of-range values leave the setting unchanged
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rate_q <= `RST_RATE;
      open_char_q <= `RST_OPEN_CHAR;
      close_char_q <= `RST_CLOSE_CHAR;
      ext_start_q <= `RST_EXT_START;
      extract_length_q <= `RST_EXT_LEN;
      pfx_len_q <= `RST_PFX_LEN;
      leading_code_filter_q <= 128'h0;
    end else if (wr) begin
      case (paddr)
        `OFS_RATE:
          if (pwdata[2:0] <= `RATE_MAX && pwdata[31:3] == 29'h0)
            rate_q <= pwdata[2:0];
        `OFS_FRAME: begin
          open_char_q <= pwdata[7:0];
          close_char_q <= pwdata[`FRAME_CLOSE_LSB +: 8];
        end
        `OFS_EXTRACT: begin
          if (in_range(pwdata[5:0]) && pwdata[7:6] == 2'b00)
            ext_start_q <= pwdata[5:0];
          if (in_range(pwdata[`EXTRACT_LEN_LSB +: 6]) &&
              pwdata[15:14] == 2'b00)
            extract_length_q <= pwdata[`EXTRACT_LEN_LSB +: 6];
        end
        `OFS_PFX_LEN:
          if (pwdata[31:5] == 27'h0 && pwdata[4:0] <= `PFX_MAX)
            pfx_len_q <= pwdata[4:0];
        `OFS_PFX_W0: leading_code_filter_q[31:0] <= pwdata;
        `OFS_PFX_W1: leading_code_filter_q[63:32] <= pwdata;
        `OFS_PFX_W2: leading_code_filter_q[95:64] <= pwdata;
        `OFS_PFX_W3: leading_code_filter_q[127:96] <= pwdata;
        default: ;
      endcase
    end
  end

  // framing of received characters
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      collecting_q <= 1'b0;
      overflow_q <= 1'b0;
      cnt_q <= 6'h00;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (rx_valid) begin
        if (rx_data == open_char_q) begin
          collecting_q <= 1'b1;
          overflow_q <= 1'b0;
          cnt_q <= 6'h00;
        end else if (collecting_q) begin
          if (rx_data == close_char_q) begin
            collecting_q <= 1'b0;
            done_q <= 1'b1;
          end else if (cnt_q == `CODE_MAX) begin
            // too long: the code is kept flagged and rejected at close
            overflow_q <= 1'b1;
          end else begin
            cnt_q <= cnt_q + 6'h01;
          end
        end
      end
    end
  end

  always @(posedge pclk) begin
    if (rx_valid && collecting_q && rx_data != open_char_q &&
        rx_data != close_char_q && cnt_q < `CODE_MAX)
      code_mem[cnt_q] <= rx_data;
  end

  // substring extraction and prefix check on the stored code
  reg [8*CODE_CHARS-1:0] ext_code;
  reg [6:0] avail;
  reg [5:0] out_len;
  reg [6:0] idx;
  reg pfx_ok;
  integer k;

  always @* begin
    ext_code = {8*CODE_CHARS{1'b0}};
    idx = 7'h00;
    avail = {1'b0, cnt_q} + 7'h01 - {1'b0, ext_start_q};
    if (cnt_q < ext_start_q)
      out_len = 6'h00;
    else if (avail < {1'b0, extract_length_q})
      out_len = avail[5:0];
    else
      out_len = extract_length_q;
    for (k = 0; k < CODE_CHARS; k = k + 1) begin
      idx = {1'b0, ext_start_q} - 7'h01 + k[6:0];
      if (k[5:0] < out_len && idx < CODE_CHARS)
        ext_code[8*k +: 8] = code_mem[idx[5:0]];
    end
    pfx_ok = (cnt_q >= {1'b0, pfx_len_q});
    for (k = 0; k < 16; k = k + 1) begin
      if (k[4:0] < pfx_len_q && k < CODE_CHARS &&
          code_mem[k] != leading_code_filter_q[8*k +: 8])
        pfx_ok = 1'b0;
    end
  end

  // record issue, one cycle after done_q flags the close character
  wire accept = !overflow_q && (cnt_q >= ext_start_q) && pfx_ok;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rec_valid_q <= 1'b0;
      rec_reject_q <= 1'b0;
      rec_len_q <= 6'h00;
      rec_code_q <= {8*CODE_CHARS{1'b0}};
      acc_cnt_q <= 16'h0000;
      rej_cnt_q <= 16'h0000;
    end else begin
      rec_valid_q <= done_q && accept;
      rec_reject_q <= done_q && !accept;
      if (done_q && accept) begin
        rec_len_q <= out_len;
        rec_code_q <= ext_code;
        acc_cnt_q <= acc_cnt_q + 16'h0001;
      end
      if (done_q && !accept)
        rej_cnt_q <= rej_cnt_q + 16'h0001;
    end
  end

endmodule // scanner_frame_receiver

`default_nettype wire

/* File: scanner_frame_receiver_defs.vh */
`ifndef SCANNER_FRAME_RECEIVER_DEFS_VH
`define SCANNER_FRAME_RECEIVER_DEFS_VH

// register byte offsets
`define OFS_RATE        12'h000
`define OFS_FRAME       12'h004
`define OFS_EXTRACT     12'h008
`define OFS_PFX_LEN     12'h00C
`define OFS_PFX_W0      12'h010
`define OFS_PFX_W1      12'h014
`define OFS_PFX_W2      12'h018
`define OFS_PFX_W3      12'h01C
`define OFS_STATUS      12'h020
`define OFS_COUNTS      12'h024
`define OFS_LAST        12'h028

// reset values
`define RST_RATE        3'h3
`define RST_OPEN_CHAR   8'h02
`define RST_CLOSE_CHAR  8'h0D
`define RST_EXT_START   6'h01
`define RST_EXT_LEN     6'h28
`define RST_PFX_LEN     5'h00

// field positions
`define FRAME_CLOSE_LSB 8
`define EXTRACT_LEN_LSB 8
`define COUNTS_REJ_LSB  16

// limits
`define RATE_MAX        3'h4
`define CODE_MAX        6'h28
`define PFX_MAX         5'h10

// serial timing
`define CLK_HZ          20000000
`define BPS_1200        1200
`define BPS_2400        2400
`define BPS_4800        4800
`define BPS_9600        9600
`define BPS_19200       19200

`endif

/* File: scanner_model.sv */
`timescale 1ns/1ns
`default_nettype none
module scanner_model (
  // clock
  input wire logic pclk,
  // serial line, idles high between characters
  output var logic rxd
);
  initial rxd = 1'b1;
  task automatic send_bit(logic b, int cyc);
    rxd <= b;
    repeat (cyc) @(posedge pclk);
  endtask
  task automatic send(string s, int cyc);
    byte c;
    for (int k = 0; k < s.len(); k++) begin
      c = s[k];
      send_bit(1'b0, cyc);
      for (int i = 0; i < 8; i++) send_bit(c[i], cyc);
      send_bit(1'b1, cyc);
    end
  endtask
endmodule // scanner_model
`default_nettype wire

/* File: serial_byte_rx.v */
`timescale 1ns/1ns
`default_nettype none
`include "scanner_frame_receiver_defs.vh"

module serial_byte_rx #(
  parameter CLK_HZ = `CLK_HZ
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // configuration
  input wire [2:0] rate,
  // serial line
  input wire rxd,
  // received byte
  output reg [7:0] rx_data_q,
  output reg rx_valid_q,
  output reg rx_ferr_q
);

  localparam ST_IDLE = 2'd0;
  localparam ST_START = 2'd1;
  localparam ST_DATA = 2'd2;
  localparam ST_STOP = 2'd3;

  // bit period in clock cycles, rounded down
  // the quotient is computed at 32 bits; 16 bits cover 1200 bps at 20 MHz
  function [15:0] bit_cycles;
    input [2:0] code;
    reg [31:0] full;
    begin
      case (code)
        3'h0: full = CLK_HZ / `BPS_1200;
        3'h1: full = CLK_HZ / `BPS_2400;
        3'h2: full = CLK_HZ / `BPS_4800;
        3'h3: full = CLK_HZ / `BPS_9600;
        default: full = CLK_HZ / `BPS_19200;
      endcase
      bit_cycles = full[15:0];
    end
  endfunction

  reg [1:0] st_q;
  reg [15:0] cnt_q;
  reg [2:0] bit_q;
  reg [7:0] shift_q;
  wire [15:0] period = bit_cycles(rate);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= ST_IDLE;
      cnt_q <= 16'h0000;
      bit_q <= 3'h0;
      shift_q <= 8'h00;
      rx_data_q <= 8'h00;
      rx_valid_q <= 1'b0;
      rx_ferr_q <= 1'b0;
    end else begin
      rx_valid_q <= 1'b0;
      rx_ferr_q <= 1'b0;
      case (st_q)
        ST_IDLE: begin
          cnt_q <= 16'h0000;
          if (!rxd) st_q <= ST_START;
        end
        ST_START: begin
          // confirm start bit at its middle, reject glitches
          if (cnt_q >= {1'b0, period[15:1]}) begin
            cnt_q <= 16'h0000;
            bit_q <= 3'h0;
            st_q <= rxd ? ST_IDLE : ST_DATA;
          end else cnt_q <= cnt_q + 16'h0001;
        end
        ST_DATA: begin
          if (cnt_q >= period - 16'h0001) begin
            cnt_q <= 16'h0000;
            shift_q <= {rxd, shift_q[7:1]};
            bit_q <= bit_q + 3'h1;
            if (bit_q == 3'h7) st_q <= ST_STOP;
          end else cnt_q <= cnt_q + 16'h0001;
        end
        ST_STOP: begin
          if (cnt_q >= period - 16'h0001) begin
            cnt_q <= 16'h0000;
            st_q <= ST_IDLE;
            rx_data_q <= shift_q;
            rx_valid_q <= rxd;
            rx_ferr_q <= !rxd;
          end else cnt_q <= cnt_q + 16'h0001;
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

endmodule // serial_byte_rx

`default_nettype wire

/* File: sfr_monitor.sv */
`timescale 1ns/1ns
`default_nettype none
module sfr_monitor #(
  parameter int CODE_CHARS = 40
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  // serial and record
  input wire logic scan_rxd,
  input wire logic rec_valid_q,
  input wire logic rec_reject_q,
  input wire logic [5:0] rec_len_q,
  input wire logic [8*CODE_CHARS-1:0] rec_code_q
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic rec = rec_valid_q || rec_reject_q;
  property p_one; rec_valid_q |-> !rec_reject_q; endproperty
  a_one: assert property (p_one)
    else $error("record both accepted and rejected");
  // two frames need at least two characters, far more than 8 cycles
  property p_gap; rec |=> !rec [*8]; endproperty
  a_gap: assert property (p_gap)
    else $error("records too close together");
  property p_len; rec_valid_q |-> rec_len_q inside {[1:40]}; endproperty
  a_len: assert property (p_len)
    else $error("record length out of range");
  property p_pad; rec_valid_q |-> (rec_code_q >> (8*rec_len_q)) == '0;
  endproperty
  a_pad: assert property (p_pad)
    else $error("record has characters past its length");
  property p_hold; !rec_valid_q |-> $stable(rec_code_q); endproperty
  a_hold: assert property (p_hold)
    else $error("record code changed without a record");
  property p_stop; rec |-> $past(scan_rxd, 4); endproperty
  a_stop: assert property (p_stop)
    else $error("record issued without a stop bit");
  property p_err; psel && penable && paddr > 12'h028 |-> pslverr;
  endproperty
  a_err: assert property (p_err)
    else $error("unmapped access without error");
  property p_ok;
    psel && penable && paddr <= 12'h028 && paddr[1:0] == 2'h0 |-> !pslverr;
  endproperty
  a_ok: assert property (p_ok)
    else $error("mapped access flagged as error");
  c_acc: cover property (rec_valid_q);
  c_rej: cover property (rec_reject_q);
  c_err: cover property (psel && penable && pslverr);
endmodule // sfr_monitor
`default_nettype wire

/* File: tb.sv */
`timescale 1ns/1ns
`default_nettype none
module tb;
  // slow clock setting keeps a bit at 10 to 160 cycles
  localparam int HZ = 192000;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, err, rec_valid, rec_reject, got_ok;
  logic [5:0] rec_len, got_len;
  logic [319:0] rec_code, got_code;
  wire logic rxd;
  int num_errors = 0, cmp_count = 0, n_rec = 0;
  always #25 pclk = ~pclk;
  scanner_frame_receiver #(.CLK_HZ(HZ)) dut_u (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .scan_rxd(rxd), .rec_valid_q(rec_valid),
    .rec_reject_q(rec_reject), .rec_len_q(rec_len), .rec_code_q(rec_code));
  scanner_model sm_u (.pclk(pclk), .rxd(rxd));
  always @(posedge pclk) if (rec_valid || rec_reject) begin
    n_rec <= n_rec + 1;
    got_ok <= rec_valid;
    got_len <= rec_len;
    got_code <= rec_code;
  end
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(string nm, logic [319:0] e, logic [319:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    chk("pready", 1'b1, pready);
    if (i == 20) wrap_up;
  endtask
  task automatic frame(string s, int cyc, logic ok, string e);
    int n;
    logic [319:0] c;
    n = n_rec;
    c = '0;
    for (int k = 0; k < e.len(); k++) c[8*k +: 8] = e[k];
    sm_u.send(s, cyc);
    for (int i = 0; i < 4 * cyc && n_rec == n; i++) @(posedge pclk);
    @(posedge pclk);
    chk("records", n + 1, n_rec);
    if (n_rec == n) wrap_up;
    else begin
      chk("accepted", ok, got_ok);
      if (ok) chk("length", e.len(), got_len);
      if (ok) chk("code", c, got_code);
    end
  endtask
  task automatic t_reset;
    apb(0, 12'h000, 0);
    chk("rate", 3'h3, rd);
    apb(0, 12'h004, 0);
    chk("frame", 16'h0d02, rd);
    apb(0, 12'h008, 0);
    chk("extract", 16'h2801, rd);
    frame("\002AB\015", HZ / 9600, 1, "AB");
    $display("done reset");
  endtask
  task automatic t_rates;
    int bps[5] = '{1200, 2400, 4800, 9600, 19200};
    for (int r = 0; r < 5; r++) begin
      apb(1, 12'h000, r);
      frame("\0027\015", HZ / bps[r], 1, "7");
    end
    apb(1, 12'h000, 5);
    apb(0, 12'h000, 0);
    chk("rate kept", 3'h4, rd);
    $display("done rates");
  endtask
  task automatic t_frame;
    apb(1, 12'h004, 16'h4241);
    frame("xA123A45B", 10, 1, "45");
    apb(1, 12'h008, 16'h0302);
    frame("A12345B", 10, 1, "234");
    frame("A123B", 10, 1, "23");
    apb(1, 12'h008, 16'h0203);
    frame("A12B", 10, 0, "");
    apb(1, 12'h008, 16'h2900);
    apb(0, 12'h008, 0);
    chk("extract kept", 16'h0203, rd);
    $display("done frame");
  endtask
  task automatic t_prefix;
    apb(1, 12'h008, 16'h2801);
    apb(1, 12'h010, 32'h0033_3231);
    apb(1, 12'h00c, 5'h03);
    frame("A1234B", 10, 1, "1234");
    frame("A14377B", 10, 0, "");
    apb(0, 12'h030, 0);
    chk("slverr", 1'b1, err);
    chk("unmapped", 1'b0, rd);
    // ten accepted and two rejected codes so far, last one four long
    apb(0, 12'h024, 0);
    chk("counts", 32'h0002_000a, rd);
    apb(0, 12'h028, 0);
    chk("last", 6'h04, rd);
    $display("done prefix");
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1;
    t_reset;
    t_rates;
    t_frame;
    t_prefix;
    wrap_up;
  end
endmodule // tb
bind scanner_frame_receiver sfr_monitor #(.CODE_CHARS(CODE_CHARS)) mon_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .prdata(prdata), .scan_rxd(scan_rxd),
  .rec_valid_q(rec_valid_q), .rec_reject_q(rec_reject_q),
  .rec_len_q(rec_len_q), .rec_code_q(rec_code_q));
`default_nettype wire
